// ===== verilog/atx_pkg.sv
// shared constants and types of the audio frame transmitter
package atx_pkg;

	// ------------------------------------------------------------
	// register map (word index; byte address is four times it)
	// ------------------------------------------------------------
	localparam int          ADDR_W   = 18;
	localparam logic [15:0] DATA_IDX = 16'hffdd;
	localparam logic [15:0] CTRL_IDX = 16'hffde;
	localparam logic [15:0] STAT_IDX = 16'hffdf;
	localparam logic [15:0] VEC_IDX  = 16'hffdc;

	localparam logic [23:0] CTRL_WMASK = 24'h00fc1f;
	localparam int          STAT_EMPTY_BIT    = 0;
	localparam int          STAT_UNDERRUN_BIT = 2;
	localparam int          STAT_BLOCK_BIT    = 3;
	localparam int          STAT_BUSY_BIT     = 4;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// interrupt vectors
	// ------------------------------------------------------------
	localparam logic [15:0] VEC_UNDERRUN = 16'h0050;
	localparam logic [15:0] VEC_BLOCK    = 16'h0052;
	localparam logic [15:0] VEC_EMPTY    = 16'h0056;

	// ------------------------------------------------------------
	// frame timing: 64 slots per sub-frame, 128 per frame
	// ------------------------------------------------------------
	localparam logic [6:0] SLOT_LAST  = 7'h7f;
	localparam logic [5:0] PRE_SLOTS  = 6'h08;
	localparam logic [5:0] PAR_SLOT   = 6'h3e;
	localparam logic [7:0] FRAME_LAST = 8'hbf;
	localparam logic [7:0] PRE_X      = 8'he2;
	localparam logic [7:0] PRE_Y      = 8'he4;
	localparam logic [7:0] PRE_Z      = 8'he8;

	// clock source select and slot dividers (last count value)
	localparam logic [1:0] CS_CORE        = 2'h0;
	localparam logic [1:0] CS_EXT_256     = 2'h1;
	localparam logic [1:0] CS_EXT_384     = 2'h2;
	localparam logic [2:0] MCLK_SLOT_LAST = 3'h7;
	localparam logic [2:0] EXT256_LAST    = 3'h1;
	localparam logic [2:0] EXT384_LAST    = 3'h2;
	localparam logic [2:0] EXT512_LAST    = 3'h3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic {ATX_IDLE, ATX_SEND} atx_run_t;

	typedef struct packed {
		logic [7:0] rsv_hi;
		logic       cb;
		logic       ub;
		logic       vb;
		logic       ca;
		logic       ua;
		logic       va;
		logic [4:0] rsv_mid;
		logic [1:0] cs;
		logic       stp;
		logic       irq_en;
		logic       en;
	} atx_ctrl_t;

	typedef struct packed {
		atx_run_t    run;
		logic [6:0]  slot;
		logic [7:0]  frame;
		logic        line_n;
		logic        ref_lvl;
		logic [26:0] shreg;
		logic        par;
		logic [23:0] chan_a_audio_word;
		logic [23:0] chan_b_audio_word;
		logic [23:0] chan_b_audio_hold;
		logic [2:0]  chan_b_nonaudio_hold;
		logic        wr_sel_b;
		logic        data_empty_flag;
		logic        underrun_flag;
		logic        block_done_flag;
		atx_ctrl_t   ctrl;
		logic        aw_got;
		logic [15:0] aw_idx;
		logic        w_got;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} atx_tx_state_t;

	typedef struct packed {
		logic       sync1;
		logic       sync2;
		logic       sync3;
		logic [2:0] cnt;
		logic       tick;
	} atx_tim_state_t;

endpackage

// ===== verilog/atx_slot_timer.sv
// time-slot tick generator for the audio frame transmitter
`timescale 1ns/10ps
module atx_slot_timer (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       nrst,
	// control
	input  wire logic       run,
	input  wire logic [1:0] clock_source_select,
	// external oversampled clock pin
	input  wire logic       external_audio_clock_in,
	// one pulse per time slot
	output logic            slot_tick
);

	atx_pkg::atx_tim_state_t st;
	atx_pkg::atx_tim_state_t nx;
	logic                    step;
	logic [2:0]              last;

	function automatic logic [2:0] slot_last(input logic [1:0] cs);
		case (cs)
			atx_pkg::CS_CORE:    slot_last = atx_pkg::MCLK_SLOT_LAST;
			atx_pkg::CS_EXT_256: slot_last = atx_pkg::EXT256_LAST;
			atx_pkg::CS_EXT_384: slot_last = atx_pkg::EXT384_LAST;
			default:             slot_last = atx_pkg::EXT512_LAST;
		endcase
	endfunction

	// ------------------------------------------------------------
	// master counts core cycles, slave counts pin edges
	// ------------------------------------------------------------
	// edge detect looks at the second and third stages only
	assign step = (clock_source_select == atx_pkg::CS_CORE) ? 1'b1 :
		(st.sync2 & ~st.sync3);
	assign last = slot_last(clock_source_select);

	always_comb
	begin
		nx       = st;
		nx.sync1 = external_audio_clock_in;
		nx.sync2 = st.sync1;
		nx.sync3 = st.sync2;
		nx.tick  = 1'b0;
		if (!run)
			nx.cnt = 3'h0;
		else if (step)
		begin
			if (st.cnt == last)
			begin
				nx.cnt  = 3'h0;
				nx.tick = 1'b1;
			end
			else
				nx.cnt = st.cnt + 3'h1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
			st <= '0;
		else
			st <= nx;
	end

	assign slot_tick = st.tick;

endmodule

// ===== verilog/atx_transmitter.sv
// audio frame transmitter: register slave, framing and biphase encoder
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/10ps

module atx_transmitter (
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        nrst,
	// axi4-lite write address
	input  wire logic [atx_pkg::ADDR_W-1:0]  awaddr,
	input  wire logic [2:0]                  awprot,
	input  wire logic                        awvalid,
	output logic                             awready,
	// axi4-lite write data
	input  wire logic [31:0]                 wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	// axi4-lite write response
	output logic [1:0]                       bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	// axi4-lite read address
	input  wire logic [atx_pkg::ADDR_W-1:0]  araddr,
	input  wire logic [2:0]                  arprot,
	input  wire logic                        arvalid,
	output logic                             arready,
	// axi4-lite read data
	output logic [31:0]                      rdata,
	output logic [1:0]                       rresp,
	output logic                             rvalid,
	input  wire logic                        rready,
	// audio link
	input  wire logic                        external_audio_clock_in,
	output logic                             serial_audio_out,
	// interrupt request to the core
	output logic                             irq_req,
	output logic [15:0]                      irq_vector
);

	atx_pkg::atx_tx_state_t st;
	atx_pkg::atx_tx_state_t nx;
	logic                   tick;
	logic                   starting;
	logic                   boundary;
	logic                   halt_now;
	logic                   stop_edge;
	logic                   upload;
	logic                   advance;
	logic                   do_wr;
	logic                   wr_b;
	logic                   cell_edge;
	logic [6:0]             ns;
	logic [5:0]             sub;
	logic [7:0]             frame_nx;
	logic [15:0]            ar_idx;
	logic [23:0]            ctrl_merged;
	logic                   timer_run;

	// byte-lane merge for the 24-bit control register
	function automatic logic [23:0] merge24(input logic [23:0] old,
		input logic [23:0] val, input logic [2:0] strb);
		logic [23:0] res;
		res = old;
		for (int i = 0; i < 3; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = val[i*8 +: 8];
		end
		return res;
	endfunction

	// ------------------------------------------------------------
	// slot timing
	// ------------------------------------------------------------
	atx_slot_timer u_timer (
		.mclk                    (mclk),
		.nrst                    (nrst),
		.run                     (timer_run),
		.clock_source_select     (st.ctrl.cs),
		.external_audio_clock_in (external_audio_clock_in),
		.slot_tick               (tick)
	);

	// ------------------------------------------------------------
	// sequencing terms
	// ------------------------------------------------------------
	assign starting  = (st.run == atx_pkg::ATX_IDLE) && st.ctrl.en && tick;
	assign boundary  = (st.run == atx_pkg::ATX_SEND) && tick &&
		(st.slot == atx_pkg::SLOT_LAST);
	assign halt_now  = !st.ctrl.en && !st.ctrl.stp;
	assign stop_edge = boundary && !st.ctrl.en;
	assign upload    = starting || (boundary && st.ctrl.en);
	assign advance   = !halt_now && !stop_edge &&
		(starting || ((st.run == atx_pkg::ATX_SEND) && tick));
	assign ns        = starting ? 7'h00 : st.slot + 7'h01;
	assign sub       = ns[5:0];
	assign frame_nx  = (starting || st.frame == atx_pkg::FRAME_LAST) ?
		8'h00 : st.frame + 8'h01;
	assign cell_edge = advance && (sub >= atx_pkg::PRE_SLOTS) && !sub[0];
	// a frame that stops at its boundary still needs its slot ticks
	assign timer_run = st.ctrl.en ||
		(st.run == atx_pkg::ATX_SEND);

	// ------------------------------------------------------------
	// bus terms
	// ------------------------------------------------------------
	assign awready     = !st.aw_got;
	assign wready      = !st.w_got;
	assign arready     = !st.rvalid;
	assign do_wr       = st.aw_got && st.w_got && !st.bvalid;
	assign wr_b        = do_wr && (st.aw_idx == atx_pkg::DATA_IDX) &&
		st.wr_sel_b;
	assign ar_idx      = araddr[17:2];
	assign ctrl_merged = merge24(st.ctrl, st.wdata[23:0], st.wstrb[2:0]) &
		atx_pkg::CTRL_WMASK;

	always_comb
	begin
		logic [7:0] pat;
		logic       lvl;
		logic       refv;
		logic       dbit;
		pat  = 8'h00;
		lvl  = 1'b1;
		refv = 1'b1;
		dbit = 1'b0;
		nx   = st;

		// write channels are taken in either order
		if (awvalid && !st.aw_got)
		begin
			nx.aw_got = 1'b1;
			nx.aw_idx = awaddr[17:2];
		end
		if (wvalid && !st.w_got)
		begin
			nx.w_got = 1'b1;
			nx.wdata = wdata;
			nx.wstrb = wstrb;
		end
		if (st.bvalid && bready)
			nx.bvalid = 1'b0;
		if (do_wr)
		begin
			nx.aw_got = 1'b0;
			nx.w_got  = 1'b0;
			nx.bvalid = 1'b1;
			nx.bresp  = atx_pkg::RESP_OKAY;
			case (st.aw_idx)
				atx_pkg::CTRL_IDX:
					nx.ctrl = atx_pkg::atx_ctrl_t'(ctrl_merged);
				atx_pkg::STAT_IDX:
				begin
					if (st.wdata[atx_pkg::STAT_UNDERRUN_BIT])
						nx.underrun_flag = 1'b0;
					if (st.wdata[atx_pkg::STAT_BLOCK_BIT])
						nx.block_done_flag = 1'b0;
				end
				atx_pkg::DATA_IDX:
				begin
					if (!st.wr_sel_b)
					begin
						nx.chan_a_audio_word = st.wdata[23:0];
						nx.wr_sel_b          = 1'b1;
					end
					else
					begin
						nx.chan_b_audio_word = st.wdata[23:0];
						nx.wr_sel_b          = 1'b0;
						nx.data_empty_flag   = 1'b0;
					end
				end
				atx_pkg::VEC_IDX:
					nx.bresp = atx_pkg::RESP_OKAY;
				default:
					nx.bresp = atx_pkg::RESP_SLVERR;
			endcase
		end

		// read channel: data answer one cycle after the address
		if (st.rvalid && rready)
			nx.rvalid = 1'b0;
		if (arvalid && !st.rvalid)
		begin
			nx.rvalid = 1'b1;
			nx.rdata  = 32'h00000000;
			nx.rresp  = atx_pkg::RESP_OKAY;
			case (ar_idx)
				atx_pkg::CTRL_IDX:
					nx.rdata = {8'h00, st.ctrl};
				atx_pkg::STAT_IDX:
				begin
					nx.rdata[atx_pkg::STAT_EMPTY_BIT]    = st.data_empty_flag;
					nx.rdata[atx_pkg::STAT_UNDERRUN_BIT] = st.underrun_flag;
					nx.rdata[atx_pkg::STAT_BLOCK_BIT]    = st.block_done_flag;
					nx.rdata[atx_pkg::STAT_BUSY_BIT]     =
						(st.run == atx_pkg::ATX_SEND);
				end
				atx_pkg::VEC_IDX:
					nx.rdata = {16'h0000, irq_vector};
				atx_pkg::DATA_IDX:
					nx.rdata = 32'h00000000;
				default:
					nx.rresp = atx_pkg::RESP_SLVERR;
			endcase
		end

		// frame engine; placed last so hardware sets beat software clears
		if (halt_now || stop_edge)
		begin
			nx.run    = atx_pkg::ATX_IDLE;
			nx.slot   = 7'h00;
			nx.frame  = 8'h00;
			nx.line_n = 1'b0;
		end
		else if (advance)
		begin
			nx.run  = atx_pkg::ATX_SEND;
			nx.slot = ns;
			if (upload)
			begin
				nx.chan_b_audio_hold    = st.chan_b_audio_word;
				nx.chan_b_nonaudio_hold = {st.ctrl.cb, st.ctrl.ub, st.ctrl.vb};
				if (st.data_empty_flag)
					nx.underrun_flag = 1'b1;
				nx.data_empty_flag = 1'b1;
				nx.wr_sel_b        = 1'b0;
				nx.frame           = frame_nx;
				if (!starting && st.frame == atx_pkg::FRAME_LAST)
					nx.block_done_flag = 1'b1;
			end
			if (sub < atx_pkg::PRE_SLOTS)
			begin
				// preambles break the cell rule on purpose
				if (sub == 6'h00)
				begin
					refv       = ~st.line_n;
					nx.ref_lvl = refv;
					nx.par     = 1'b0;
					if (ns[6])
						nx.shreg = {st.chan_b_nonaudio_hold,
							st.chan_b_audio_hold};
					else
						nx.shreg = {st.ctrl.ca, st.ctrl.ua, st.ctrl.va,
							st.chan_a_audio_word};
				end
				else
					refv = st.ref_lvl;
				if (ns[6])
					pat = atx_pkg::PRE_Y;
				else if (nx.frame == 8'h00)
					pat = atx_pkg::PRE_Z;
				else
					pat = atx_pkg::PRE_X;
				lvl = pat[~sub[2:0]] ^ refv;
			end
			else if (sub < atx_pkg::PAR_SLOT)
			begin
				dbit = st.shreg[0];
				if (!sub[0])
					lvl = st.line_n;
				else
				begin
					lvl      = ~st.line_n ^ dbit;
					nx.shreg = {1'b0, st.shreg[26:1]};
					nx.par   = st.par ^ dbit;
				end
			end
			else if (!sub[0])
				lvl = st.line_n;
			else
				lvl = ~st.line_n ^ st.par;
			nx.line_n = ~lvl;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
			st <= '0;
		else
			st <= nx;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign serial_audio_out = ~st.line_n;
	assign bvalid           = st.bvalid;
	assign bresp            = st.bresp;
	assign rvalid           = st.rvalid;
	assign rdata            = st.rdata;
	assign rresp            = st.rresp;
	assign irq_req = st.data_empty_flag && st.ctrl.irq_en;

	always_comb
	begin
		if (!irq_req)
			irq_vector = 16'h0000;
		else if (st.underrun_flag)
			irq_vector = atx_pkg::VEC_UNDERRUN;
		else if (st.block_done_flag)
			irq_vector = atx_pkg::VEC_BLOCK;
		else
			irq_vector = atx_pkg::VEC_EMPTY;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_idle_high;
		@(posedge mclk) disable iff (!nrst)
		(st.run == atx_pkg::ATX_IDLE) |-> serial_audio_out;
	endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("line not high while idle");

	property p_upload_empty;
		@(posedge mclk) disable iff (!nrst)
		upload |=> st.data_empty_flag && !st.wr_sel_b;
	endproperty
	a_upload_empty: assert property (p_upload_empty)
		else $error("upload did not set empty flag");

	property p_underrun;
		@(posedge mclk) disable iff (!nrst)
		(upload && st.data_empty_flag) |=> st.underrun_flag;
	endproperty
	a_underrun: assert property (p_underrun)
		else $error("missed underrun");

	property p_b_write;
		@(posedge mclk) disable iff (!nrst)
		(wr_b && !upload) |=> !st.data_empty_flag;
	endproperty
	a_b_write: assert property (p_b_write)
		else $error("channel b write left empty flag set");

	property p_stop_now;
		@(posedge mclk) disable iff (!nrst)
		(!st.ctrl.en && !st.ctrl.stp) |=> st.run == atx_pkg::ATX_IDLE;
	endproperty
	a_stop_now: assert property (p_stop_now)
		else $error("immediate stop not taken");

	property p_priority;
		@(posedge mclk) disable iff (!nrst)
		(irq_req && st.underrun_flag) |-> irq_vector == 16'h0050;
	endproperty
	a_priority: assert property (p_priority)
		else $error("underrun vector not chosen first");

	property p_irq_gate;
		@(posedge mclk) disable iff (!nrst)
		upload |=> irq_req || !st.ctrl.irq_en;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("no request after upload");

	property p_cell_edge;
		@(posedge mclk) disable iff (!nrst)
		cell_edge |=> serial_audio_out != $past(serial_audio_out);
	endproperty
	a_cell_edge: assert property (p_cell_edge)
		else $error("no transition at cell start");

	property p_shift_done;
		@(posedge mclk) disable iff (!nrst)
		(st.run == atx_pkg::ATX_SEND && st.slot[5:0] == 6'h3e) |->
			st.shreg == 27'h0000000;
	endproperty
	a_shift_done: assert property (p_shift_done)
		else $error("shifter not drained at parity slot");

	property p_block;
		@(posedge mclk) disable iff (!nrst)
		(boundary && upload && st.frame == 8'hbf) |=>
			st.block_done_flag && st.frame == 8'h00;
	endproperty
	a_block: assert property (p_block)
		else $error("block end not flagged");

endmodule

// ===== test/atx_rx_model.sv
// behavioural audio receiver and clock source at the far end of the link
`timescale 1ns/10ps
module atx_rx_model (
	// clock of the capture grid
	input  wire logic         mclk,
	// audio link
	input  wire logic         serial_audio_out,
	output logic              external_audio_clock_in,
	// capture setup and captured frames
	input  wire logic [4:0]   slot_mclk,
	output logic [128:0]      frame_bits,
	output int                frame_cnt
);
	logic [128:0] cap;
	int           high_run = 0;
	int           i;
	// ----------------------------------------
	// oversampled clock and slot capture
	// ----------------------------------------
	// 20 ns period: 2, 3 or 4 edges give 8, 12 or 16 mclk slots
	initial
	begin
		external_audio_clock_in = 1'b0;
		forever #10 external_audio_clock_in = ~external_audio_clock_in;
	end
	// no legal biphase run is this long, so it marks an idle link
	always @(posedge mclk)
		high_run <= serial_audio_out ? high_run + 1 : 0;
	// bit 0 keeps the level before the frame, bit n+1 slot n
	initial
	begin
		frame_cnt = 0;
		frame_bits = '1;
		forever
		begin
			@(negedge serial_audio_out);
			cap[0] = 1'b1;
			repeat (slot_mclk / 2) @(posedge mclk);
			while (high_run < 64)
			begin
				for (i = 1; i <= 128 && high_run < 64; i++)
				begin
					cap[i] = serial_audio_out;
					repeat (slot_mclk) @(posedge mclk);
				end
				if (high_run < 64)
				begin
					frame_bits = cap;
					frame_cnt++;
				end
				cap[0] = cap[128];
			end
		end
	end
endmodule

// ===== test/atx_transmitter_tb.sv
// self-checking bench for the audio frame transmitter
`timescale 1ns/10ps
`define CHK(nm, e, g) \
	begin \
		num_checks++; \
		if ((g) !== (e)) \
		begin \
			$display("MISMATCH %s exp %0h got %0h", nm, e, g); \
			n_mismatch++; \
		end \
	end
module atx_transmitter_tb;
	logic         mclk, nrst, awvalid, awready, wvalid, wready, bvalid;
	logic         bready, arvalid, arready, rvalid, rready, irq_req;
	logic         external_audio_clock_in, serial_audio_out;
	logic [17:0]  awaddr, araddr;
	logic [2:0]   awprot, arprot;
	logic [31:0]  wdata, rdata, rd;
	logic [3:0]   wstrb;
	logic [1:0]   bresp, rresp;
	logic [15:0]  irq_vector;
	logic [4:0]   slot_mclk;
	logic [128:0] frame_bits;
	int           frame_cnt, n_mismatch, num_checks;

	atx_transmitter atx_transmitter_i (.mclk, .nrst, .awaddr, .awprot,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .external_audio_clock_in,
		.serial_audio_out, .irq_req, .irq_vector);
	atx_rx_model atx_rx_model_i (.mclk, .serial_audio_out,
		.external_audio_clock_in, .slot_mclk, .frame_bits, .frame_cnt);

	// ----------------------------------------
	// clock, bus tasks and frame checks
	// ----------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic tmo(input bit hit);
		if (hit)
		begin
			$display("timeout waiting for the design");
			n_mismatch++;
			stop_test;
		end
	endtask

	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		int t;
		bit a, w;
		t = 0;
		a = 0;
		w = 0;
		@(posedge mclk);
		awaddr <= {idx, 2'h0};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge mclk);
			t++;
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			a |= awready === 1'b1;
			w |= wready === 1'b1;
		end
		while (!(a && w) && t < 50);
		for (; t < 50 && bvalid !== 1'b1; t++) @(posedge mclk);
		bready <= 1'b0;
		tmo(t >= 50);
		`CHK("bresp", atx_pkg::RESP_OKAY, bresp)
	endtask

	task automatic rd_reg(input logic [15:0] idx, input logic [1:0] er);
		int t;
		@(posedge mclk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge mclk);
		for (t = 0; t < 50 && arready !== 1'b1; t++) @(posedge mclk);
		arvalid <= 1'b0;
		do @(posedge mclk); while (rvalid !== 1'b1 && ++t < 50);
		rready <= 1'b0;
		rd = rdata;
		tmo(t >= 50);
		`CHK("rresp", er, rresp)
	endtask

	task automatic rdchk(input logic [15:0] idx, input logic [31:0] e);
		rd_reg(idx, atx_pkg::RESP_OKAY);
		`CHK("register", e, rd)
	endtask

	task automatic wait_frames(input int n);
		int t, f;
		f = frame_cnt + n;
		for (t = 0; t < 9000 && frame_cnt < f; t++) @(posedge mclk);
		tmo(t >= 9000);
	endtask

	// d holds C, U, V above the audio word; bits leave lowest first
	task automatic chk_sub(input int b, input logic [7:0] pre,
		input logic [26:0] d);
		logic [7:0]  p;
		logic [27:0] g;
		int          bad;
		bad = 0;
		for (int i = 0; i < 8; i++)
			p[7 - i] = frame_bits[b + i + 1] ^ frame_bits[b];
		for (int k = 0; k < 28; k++)
		begin
			g[k] = frame_bits[b + 2 * k + 9] ^ frame_bits[b + 2 * k + 10];
			bad += frame_bits[b + 2 * k + 9] == frame_bits[b + 2 * k + 8];
		end
		`CHK("preamble", pre, p)
		`CHK("cells", {^d, d}, g)
		`CHK("cell edges", 0, bad)
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rdchk(atx_pkg::CTRL_IDX, 32'h0);
		rdchk(atx_pkg::STAT_IDX, 32'h0);
		rdchk(atx_pkg::VEC_IDX, 32'h0);
		rd_reg(16'h0000, atx_pkg::RESP_SLVERR);
		wr(atx_pkg::CTRL_IDX, 32'hfffffffe);
		rdchk(atx_pkg::CTRL_IDX, 32'h0000fc1e);
		wr(atx_pkg::CTRL_IDX, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_frames;
		int t;
		wr(atx_pkg::DATA_IDX, 32'h0012a5c3);
		wr(atx_pkg::DATA_IDX, 32'h008e0071);
		wr(atx_pkg::CTRL_IDX, 32'h00008403);
		for (t = 0; t < 100 && irq_req !== 1'b1; t++) @(posedge mclk);
		tmo(t >= 100);
		`CHK("vector", atx_pkg::VEC_EMPTY, irq_vector)
		rdchk(atx_pkg::STAT_IDX, 32'h11);
		wr(atx_pkg::DATA_IDX, 32'h006d1f02);
		rdchk(atx_pkg::STAT_IDX, 32'h11);
		wr(atx_pkg::DATA_IDX, 32'h00f0e1d2);
		`CHK("irq", 1'b0, irq_req)
		wr(atx_pkg::CTRL_IDX, 32'h00006803);
		wait_frames(1);
		chk_sub(0, atx_pkg::PRE_Z, 27'h112a5c3);
		chk_sub(64, atx_pkg::PRE_Y, 27'h48e0071);
		wait_frames(1);
		chk_sub(0, atx_pkg::PRE_X, 27'h26d1f02);
		chk_sub(64, atx_pkg::PRE_Y, 27'h3f0e1d2);
		rdchk(atx_pkg::STAT_IDX, 32'h15);
		`CHK("vector", atx_pkg::VEC_UNDERRUN, irq_vector)
		wait_frames(1);
		chk_sub(0, atx_pkg::PRE_X, 27'h26d1f02);
		wr(atx_pkg::STAT_IDX, 32'h4);
		wr(atx_pkg::CTRL_IDX, 32'h1);
		rdchk(atx_pkg::STAT_IDX, 32'h11);
		`CHK("irq", 1'b0, irq_req)
		$display("test frames done");
	endtask

	task automatic t_stop;
		wr(atx_pkg::CTRL_IDX, 32'h5);
		wr(atx_pkg::CTRL_IDX, 32'h4);
		rd_reg(atx_pkg::STAT_IDX, atx_pkg::RESP_OKAY);
		`CHK("busy", 1'b1, rd[4])
		wait_frames(1);
		`CHK("line", 1'b1, serial_audio_out)
		rd_reg(atx_pkg::STAT_IDX, atx_pkg::RESP_OKAY);
		`CHK("busy", 1'b0, rd[4])
		wr(atx_pkg::CTRL_IDX, 32'h1);
		repeat (300) @(posedge mclk);
		wr(atx_pkg::CTRL_IDX, 32'h0);
		// the halt lands on the same edge at which the write response is seen
		@(posedge mclk);
		`CHK("line", 1'b1, serial_audio_out)
		rd_reg(atx_pkg::STAT_IDX, atx_pkg::RESP_OKAY);
		`CHK("busy", 1'b0, rd[4])
		$display("test stop done");
	endtask

	task automatic t_ext;
		logic [23:0] a;
		for (int cs = 1; cs < 4; cs++)
		begin
			slot_mclk = 5'(4 * cs + 4);
			a = 24'h5a0f00 + 24'(cs);
			repeat (100) @(posedge mclk);
			wr(atx_pkg::DATA_IDX, {8'h0, a});
			wr(atx_pkg::DATA_IDX, {8'h0, ~a});
			wr(atx_pkg::CTRL_IDX, 32'(cs * 8 + 1));
			wait_frames(1);
			chk_sub(0, atx_pkg::PRE_Z, {3'h0, a});
			chk_sub(64, atx_pkg::PRE_Y, {3'h0, ~a});
			wr(atx_pkg::CTRL_IDX, 32'h0);
		end
		$display("test clock sources done");
	endtask

	initial
	begin
		n_mismatch = 0;
		num_checks = 0;
		nrst = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, awprot, arprot} = 42'h0;
		wdata = 32'h0;
		wstrb = 4'hf;
		slot_mclk = 5'h08;
		repeat (8) @(posedge mclk);
		`CHK("line in reset", 1'b1, serial_audio_out)
		nrst <= 1'b1;
		t_reset;
		t_frames;
		t_stop;
		t_ext;
		stop_test;
	end
endmodule
